// ### hw/chsf_pkg.sv
package chsf_pkg;

   // Register byte addresses and bit positions
   localparam logic [31:0] STATUS_OFFSET     = 32'hfffa_8040;
   localparam logic [31:0] IRQ_STATUS_OFFSET = 32'hfffa_8050;
   localparam logic [31:0] IRQ_CLEAR_OFFSET  = 32'hfffa_8054;
   localparam logic [31:0] IRQ_ENABLE_OFFSET = 32'hfffa_8058;
   localparam logic [31:0] CONTROL_OFFSET    = 32'hfffa_805c;
   localparam int          CMD_DONE_BIT      = 0;
   localparam int          RX_AVAIL_BIT      = 1;
   localparam int          TX_TAKEN_BIT      = 2;
   localparam int          BLOCK_END_BIT     = 3;
   localparam int          XFER_ACTIVE_BIT   = 4;
   localparam int          TX_BUF_EMPTY_BIT  = 15;
   localparam int          DMA_MODE_BIT      = 0;
   localparam int          EVENT_COUNT       = 5;

   // Values after reset
   localparam logic [EVENT_COUNT-1:0] FLAGS_RESET   = 5'h05;
   localparam logic [EVENT_COUNT-1:0] IRQ_RESET     = 5'h00;
   localparam logic [31:0]            READ_FILL     = 32'h0000_0000;

   // Register-bus handshake state, for reads and writes
   typedef enum logic [1:0]
   {
      CHSF_IDLE  = 2'b00,
      CHSF_READ  = 2'b01,
      CHSF_DONE  = 2'b11
   } chsf_bus_state_type;

endpackage : chsf_pkg

// ### hw/chsf_event_if.sv
`timescale 1ns/100ps
// Flag events that travel from the top into the sticky-bit bank
interface chsf_event_if;
   logic [4:0] eventPulse;  // One-cycle rising edges of flags
   logic [4:0] clearMask;   // Software clear word
   logic       clearStrobe; // Clear word valid
   logic [4:0] enableMask;  // Interrupt enable word
   logic [4:0] stickyBits;  // Latched events
   logic       irqLevel;    // Combined interrupt, registered
   modport top (output eventPulse, output clearMask, output clearStrobe, output enableMask,
                input stickyBits, input irqLevel);
   modport bank (input eventPulse, input clearMask, input clearStrobe, input enableMask,
                 output stickyBits, output irqLevel);
endinterface : chsf_event_if

// ### hw/chsf_irq_bank.sv
`timescale 1ns/100ps
module chsf_irq_bank
   import chsf_pkg::*;
(
   input  wire logic   clock,
   input  wire logic   sys_rst,
   input  wire logic   clkEn,
   chsf_event_if.bank  ev
);

   logic [EVENT_COUNT-1:0] sticky_reg; // Latched events
   logic                   irq_reg;    // Registered interrupt level

   // Set beats clear so an event in the clear cycle is kept
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         sticky_reg <= IRQ_RESET;
      else if (clkEn)
         sticky_reg <= (sticky_reg & ~(ev.clearStrobe ? ev.clearMask : IRQ_RESET)) | ev.eventPulse;
   end

   // Level output while an enabled bit stands
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         irq_reg <= 1'b0;
      else if (clkEn)
         irq_reg <= |(((sticky_reg & ~(ev.clearStrobe ? ev.clearMask : IRQ_RESET)) | ev.eventPulse)
                      & ev.enableMask);
   end

   assign ev.stickyBits = sticky_reg;
   assign ev.irqLevel   = irq_reg;

endmodule : chsf_irq_bank

// ### hw/card_host_status_flags.sv
// Local design decision: the Avalon-MM register port.
`timescale 1ns/100ps
// What this block does
// - Command done low while sending, then set
// - Command register write clears command done
// - Receive flag sets on data, clears on read
// - Transmit flag sets when word reaches shifter
// - Status read clears block end flag
// - Block end sets after block plus CRC status
// - DMA mode: set on last CRC, buffer empty
// - No DMA: set on every CRC status
// - Transfer flag high through CRC calculation end
module card_host_status_flags
   import chsf_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire logic        clkEn,
   input  wire logic [31:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        cmdRegWrite,
   input  wire logic        cmdSent,
   input  wire logic        rxWordArrived,
   input  wire logic        rxDataRegRead,
   input  wire logic        txDataRegWrite,
   input  wire logic        txWordToShifter,
   input  wire logic        crcStatusSent,
   input  wire logic        txBufferEmpty,
   input  wire logic        xferStart,
   input  wire logic        crcCalcDone,
   output logic             irq,
   output logic             dmaAssistMode
);

   // Flag state
   logic                   cmdDone_reg;     // Command done
   logic                   rxAvail_reg;     // Receive word available
   logic                   txTaken_reg;     // Transmit word taken
   logic                   blockEnd_reg;    // Block ended
   logic                   xferActive_reg;  // Transfer in progress
   logic                   dmaMode_reg;     // DMA assistance select
   logic [EVENT_COUNT-1:0] irqEnable_reg;   // Interrupt enables
   logic [EVENT_COUNT-1:0] flagsPrev_reg;   // For rising-edge events
   logic [31:0]            readData_reg;    // Bus read data
   logic                   wait_reg;        // Bus waitrequest
   chsf_bus_state_type     busState_reg;    // Bus handshake state
   chsf_bus_state_type     busState_next;   // Next handshake state

   // Decoded bus strokes
   logic                   busIdle;         // Ready to take a request
   logic                   statusRead;      // Status word read, taken
   logic                   blockEndSet;     // Block end event
   logic [EVENT_COUNT-1:0] flagsNow;        // Current flag vector
   logic [31:0]            readValue;       // Mux of readable words
   logic                   writeTake;       // Write taken this cycle
   logic                   clearWrite;      // Write to clear word

   chsf_event_if evBus ();

   assign busIdle    = (busState_reg == CHSF_IDLE);
   assign writeTake  = busIdle && avs_write;
   // Status read counts once, in the cycle it is accepted
   assign statusRead = busIdle && avs_read && (avs_address == STATUS_OFFSET);
   assign clearWrite = writeTake && (avs_address == IRQ_CLEAR_OFFSET) && avs_byteenable[0];

   // Which CRC status ends a block depends on the DMA mode
   always_comb
   begin
      if (dmaMode_reg)
         blockEndSet = crcStatusSent && txBufferEmpty;
      else
         blockEndSet = crcStatusSent;
   end

   // Command done: cleared by a new command, set once it is sent
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         cmdDone_reg <= FLAGS_RESET[CMD_DONE_BIT];
      else if (clkEn)
      begin
         if (cmdSent)
            cmdDone_reg <= 1'b1;
         else if (cmdRegWrite)
            cmdDone_reg <= 1'b0;
      end
   end

   // Receive flag: arrival wins over a simultaneous read
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         rxAvail_reg <= FLAGS_RESET[RX_AVAIL_BIT];
      else if (clkEn)
      begin
         if (rxWordArrived)
            rxAvail_reg <= 1'b1;
         else if (rxDataRegRead)
            rxAvail_reg <= 1'b0;
      end
   end

   // Transmit flag: low after a write until the shifter takes it
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         txTaken_reg <= FLAGS_RESET[TX_TAKEN_BIT];
      else if (clkEn)
      begin
         if (txWordToShifter)
            txTaken_reg <= 1'b1;
         else if (txDataRegWrite)
            txTaken_reg <= 1'b0;
      end
   end

   // Block end: meaningful for writes only; read clears it
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         blockEnd_reg <= FLAGS_RESET[BLOCK_END_BIT];
      else if (clkEn)
      begin
         if (blockEndSet)
            blockEnd_reg <= 1'b1;
         else if (statusRead)
            blockEnd_reg <= 1'b0;
      end
   end

   // Transfer active until the CRC16 calculation ends
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         xferActive_reg <= FLAGS_RESET[XFER_ACTIVE_BIT];
      else if (clkEn)
      begin
         if (crcCalcDone)
            xferActive_reg <= 1'b0;
         else if (xferStart)
            xferActive_reg <= 1'b1;
      end
   end

   // Software-owned controls; status word writes fall through
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         dmaMode_reg   <= 1'b0;
         irqEnable_reg <= IRQ_RESET;
      end
      else if (clkEn && writeTake && avs_byteenable[0])
      begin
         case (avs_address)
            CONTROL_OFFSET:    dmaMode_reg   <= avs_writedata[DMA_MODE_BIT];
            IRQ_ENABLE_OFFSET: irqEnable_reg <= avs_writedata[EVENT_COUNT-1:0];
            default:           ;
         endcase
      end
   end

   // Edge detector feeding the sticky bank
   assign flagsNow = {xferActive_reg, blockEnd_reg, txTaken_reg, rxAvail_reg, cmdDone_reg};

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         flagsPrev_reg <= FLAGS_RESET;
      else if (clkEn)
         flagsPrev_reg <= flagsNow;
   end

   assign evBus.eventPulse  = flagsNow & ~flagsPrev_reg;
   assign evBus.clearMask   = avs_writedata[EVENT_COUNT-1:0];
   assign evBus.clearStrobe = clearWrite;
   assign evBus.enableMask  = irqEnable_reg;

   chsf_irq_bank u_bank
   (
      .clock   (clock),
      .sys_rst (sys_rst),
      .clkEn   (clkEn),
      .ev      (evBus)
   );

   // Read mux; unmapped words read as zero
   always_comb
   begin
      readValue = READ_FILL;
      case (avs_address)
         STATUS_OFFSET:
         begin
            readValue[EVENT_COUNT-1:0] = flagsNow;
            readValue[TX_BUF_EMPTY_BIT] = txBufferEmpty;
         end
         IRQ_STATUS_OFFSET: readValue[EVENT_COUNT-1:0] = evBus.stickyBits;
         IRQ_ENABLE_OFFSET: readValue[EVENT_COUNT-1:0] = irqEnable_reg;
         CONTROL_OFFSET:    readValue[DMA_MODE_BIT]     = dmaMode_reg;
         default:           readValue = READ_FILL;
      endcase
   end

   // Handshake: take in IDLE, answer one cycle later
   always_comb
   begin
      case (busState_reg)
         CHSF_IDLE: busState_next = (avs_read || avs_write) ? CHSF_READ : CHSF_IDLE;
         CHSF_READ: busState_next = CHSF_DONE;
         CHSF_DONE: busState_next = CHSF_IDLE;
         default:   busState_next = CHSF_IDLE;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         busState_reg <= CHSF_IDLE;
      else if (clkEn)
         busState_reg <= busState_next;
   end

   // Waitrequest drops in READ state; master samples at the next edge
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         wait_reg <= 1'b1;
      else if (clkEn)
         wait_reg <= !(busState_next == CHSF_READ);
   end

   // Data captured when taken, so the clearing read sees the old flag
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         readData_reg <= READ_FILL;
      else if (clkEn && busIdle && avs_read)
         readData_reg <= readValue;
   end

   assign avs_readdata    = readData_reg;
   assign avs_waitrequest = wait_reg;
   assign irq             = evBus.irqLevel;
   assign dmaAssistMode   = dmaMode_reg;

   // Block end stays clear after a status read with no new CRC status
   property p_blockEndClr;
      @(posedge clock) disable iff (sys_rst)
      (clkEn && statusRead && !blockEndSet) |=> !blockEnd_reg;
   endproperty
   a_blockEndClr: assert property (p_blockEndClr) else $error("block end not cleared by read");

   property p_cmdDone;
      @(posedge clock) disable iff (sys_rst)
      (clkEn && cmdRegWrite && !cmdSent) |=> !cmdDone_reg;
   endproperty
   a_cmdDone: assert property (p_cmdDone) else $error("command done not cleared");

   property p_cmdSent;
      @(posedge clock) disable iff (sys_rst)
      (clkEn && cmdSent) |=> cmdDone_reg;
   endproperty
   a_cmdSent: assert property (p_cmdSent) else $error("command done not set");

   property p_dmaBlock;
      @(posedge clock) disable iff (sys_rst)
      (clkEn && dmaMode_reg && crcStatusSent && !txBufferEmpty && !blockEnd_reg) |=> !blockEnd_reg;
   endproperty
   a_dmaBlock: assert property (p_dmaBlock) else $error("block end set before buffer empty");

   property p_plainBlock;
      @(posedge clock) disable iff (sys_rst)
      (clkEn && !dmaMode_reg && crcStatusSent) |=> blockEnd_reg;
   endproperty
   a_plainBlock: assert property (p_plainBlock) else $error("block end missed a CRC status");

   property p_rxFlag;
      @(posedge clock) disable iff (sys_rst)
      (clkEn && rxWordArrived) |=> rxAvail_reg;
   endproperty
   a_rxFlag: assert property (p_rxFlag) else $error("receive flag lost");

   property p_txFlag;
      @(posedge clock) disable iff (sys_rst)
      (clkEn && txDataRegWrite && !txWordToShifter) |=> !txTaken_reg;
   endproperty
   a_txFlag: assert property (p_txFlag) else $error("transmit flag not lowered");

   property p_xfer;
      @(posedge clock) disable iff (sys_rst)
      (clkEn && crcCalcDone) |=> !xferActive_reg;
   endproperty
   a_xfer: assert property (p_xfer) else $error("transfer flag stuck after CRC");

   property p_noWrite;
      @(posedge clock) disable iff (sys_rst)
      (clkEn && writeTake && avs_address == STATUS_OFFSET && !cmdSent && !cmdRegWrite) |=>
         (cmdDone_reg == $past(cmdDone_reg));
   endproperty
   a_noWrite: assert property (p_noWrite) else $error("status write changed a flag");

   property p_blockEndSet;
      @(posedge clock) disable iff (sys_rst)
      (clkEn && blockEndSet) |=> blockEnd_reg;
   endproperty
   a_blockEndSet: assert property (p_blockEndSet) else $error("block end not set");

   // A read with no new arrival must drop the receive flag
   property p_rxClr;
      @(posedge clock) disable iff (sys_rst)
      (clkEn && rxDataRegRead && !rxWordArrived) |=> !rxAvail_reg;
   endproperty
   a_rxClr: assert property (p_rxClr) else $error("receive flag not cleared by read");

   property p_txSet;
      @(posedge clock) disable iff (sys_rst)
      (clkEn && txWordToShifter) |=> txTaken_reg;
   endproperty
   a_txSet: assert property (p_txSet) else $error("transmit flag not set by shifter load");

   property p_xferSet;
      @(posedge clock) disable iff (sys_rst)
      (clkEn && xferStart && !crcCalcDone) |=> xferActive_reg;
   endproperty
   a_xferSet: assert property (p_xferSet) else $error("transfer flag not raised");

   property p_dmaBlockSet;
      @(posedge clock) disable iff (sys_rst)
      (clkEn && dmaMode_reg && crcStatusSent && txBufferEmpty) |=> blockEnd_reg;
   endproperty
   a_dmaBlockSet: assert property (p_dmaBlockSet) else $error("block end missed final CRC status");

   // Covers every flag, not only command done, when nothing else moves them
   property p_noWriteFlags;
      @(posedge clock) disable iff (sys_rst)
      (clkEn && writeTake && avs_address == STATUS_OFFSET && !cmdSent && !cmdRegWrite && !rxWordArrived
       && !rxDataRegRead && !txDataRegWrite && !txWordToShifter && !crcStatusSent && !xferStart
       && !crcCalcDone) |=> $stable(flagsNow);
   endproperty
   a_noWriteFlags: assert property (p_noWriteFlags) else $error("status write moved a flag");

   // Frozen cycles keep every flag where it was
   property p_freeze;
      @(posedge clock) disable iff (sys_rst)
      !clkEn |=> $stable(flagsNow);
   endproperty
   a_freeze: assert property (p_freeze) else $error("flag moved while clock enable low");

endmodule : card_host_status_flags

// ### sim/chsf_card_model.sv
`timescale 1ns/100ps
// Card side of the host: answers each kick with one strobe, promptly or late
// Strobe order: 0 sent, 1 rx word, 2 tx to shifter, 3 crc status, 4 crc done
module chsf_card_model
   import chsf_pkg::*;
(
   input  wire logic                   clock,
   input  wire logic                   sys_rst,
   input  wire logic [EVENT_COUNT-1:0] kick,
   input  wire logic                   slow,
   output logic      [EVENT_COUNT-1:0] pulse
);
   logic [EVENT_COUNT-1:0] pendReg; // Kicks waiting for their strobe
   logic [2:0]             waitReg; // Cycles left before the strobe

   // One job at a time; a kick while busy merges into the same strobe
   always_ff @(posedge clock)
   begin
      pulse <= '0;
      if (sys_rst)
      begin
         pendReg <= '0;
         waitReg <= '0;
      end
      else if (kick != '0)
      begin
         pendReg <= pendReg | kick;
         waitReg <= slow ? 3'h4 : 3'h1;
      end
      else if (waitReg == 3'h1)
      begin
         pulse   <= pendReg; // Single-cycle strobes
         pendReg <= '0;
         waitReg <= '0;
      end
      else if (waitReg != '0)
         waitReg <= waitReg - 3'h1;
   end
endmodule : chsf_card_model

// ### sim/card_host_status_flags_tb.sv
`timescale 1ns/100ps
// Random and corner-case run of the status flag bank over the register bus
module card_host_status_flags_tb
   import chsf_pkg::*;
;
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   logic [31:0] avs_address = '0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        clkEn = 1'b1;     // Bench clock enable
   logic [3:0]  byteEn = 4'hF;    // Write byte lanes
   logic [3:0]  swStrobe = '0;    // Cmd write, rx read, tx write, xfer start
   logic [4:0]  kick = '0;        // Card model requests
   logic [4:0]  cardPulse;        // Card model strobes
   logic        slow = 1'b0;      // Card answers late
   logic        txBufferEmpty = 1'b0;
   logic        irq;
   logic        dmaAssistMode;
   logic [4:0]  expFlags;         // Expected flag bits
   logic [31:0] rd;               // Last read data
   int          fails = 0;
   int          total_checks = 0;
   int          cycles = 0;

   always #50 clock = ~clock;

   card_host_status_flags u_dut (.clock(clock), .sys_rst(sys_rst), .clkEn(clkEn),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(byteEn), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .cmdRegWrite(swStrobe[0]), .cmdSent(cardPulse[0]),
      .rxWordArrived(cardPulse[1]), .rxDataRegRead(swStrobe[1]), .txDataRegWrite(swStrobe[2]),
      .txWordToShifter(cardPulse[2]), .crcStatusSent(cardPulse[3]), .txBufferEmpty(txBufferEmpty),
      .xferStart(swStrobe[3]), .crcCalcDone(cardPulse[4]), .irq(irq), .dmaAssistMode(dmaAssistMode));

   chsf_card_model u_card (.clock(clock), .sys_rst(sys_rst), .kick(kick), .slow(slow), .pulse(cardPulse));

   // Expected status word from flag bits and buffer state
   function automatic logic [31:0] exp_status(input logic [4:0] f, input logic e);
      exp_status = {16'h0000, e, 10'h000, f};
   endfunction : exp_status

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Bus request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
      @(posedge clock);
      avs_address   <= addr;
      avs_writedata <= wd;
      avs_read      <= !wr;
      avs_write     <= wr;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic chk_status();
      bus(1'b0, STATUS_OFFSET, '0);
      check("status", rd, exp_status(expFlags, txBufferEmpty));
      expFlags[BLOCK_END_BIT] = 1'b0;
   endtask : chk_status

   task automatic sw_pulse(input int i);
      @(posedge clock);
      swStrobe[i] <= 1'b1;
      @(posedge clock);
      swStrobe <= '0;
   endtask : sw_pulse

   task automatic card(input int i);
      @(posedge clock);
      slow    <= 1'($urandom_range(1, 0));
      kick[i] <= 1'b1;
      @(posedge clock);
      kick <= '0;
      repeat (7) @(posedge clock);
   endtask : card

   task automatic irq_chk(input logic exp);
      repeat (3) @(posedge clock);
      check("irq", {31'h0, irq}, {31'h0, exp});
   endtask : irq_chk

   task automatic test_done();
      $display("Checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done

   // Hang guard
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         test_done();
      end
   end

   initial
   begin
      void'($urandom(66252));
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      expFlags = FLAGS_RESET;
      chk_status();
      sw_pulse(0);
      expFlags[CMD_DONE_BIT] = 1'b0;
      chk_status();
      card(0);
      expFlags[CMD_DONE_BIT] = 1'b1;
      chk_status();
      card(1);
      expFlags[RX_AVAIL_BIT] = 1'b1;
      chk_status();
      sw_pulse(1);
      expFlags[RX_AVAIL_BIT] = 1'b0;
      chk_status();
      sw_pulse(2);
      expFlags[TX_TAKEN_BIT] = 1'b0;
      chk_status();
      card(2);
      expFlags[TX_TAKEN_BIT] = 1'b1;
      chk_status();
      sw_pulse(3);
      expFlags[XFER_ACTIVE_BIT] = 1'b1;
      chk_status();
      card(4);
      expFlags[XFER_ACTIVE_BIT] = 1'b0;
      chk_status();
      // Write blocks without DMA help; flag only read back in write context
      repeat ($urandom_range(4, 2))
      begin
         txBufferEmpty <= 1'($urandom_range(1, 0));
         card(3);
         expFlags[BLOCK_END_BIT] = 1'b1;
         chk_status();
         chk_status();
      end
      bus(1'b1, CONTROL_OFFSET, 32'h0000_0001);
      check("dma mode", {31'h0, dmaAssistMode}, 32'h0000_0001);
      txBufferEmpty <= 1'b0;
      card(3);
      chk_status();
      txBufferEmpty <= 1'b1;
      card(3);
      expFlags[BLOCK_END_BIT] = 1'b1;
      chk_status();
      bus(1'b1, STATUS_OFFSET, $urandom());
      chk_status();
      // Strobe during a frozen clock enable is dropped
      clkEn <= 1'b0;
      sw_pulse(0);
      clkEn <= 1'b1;
      chk_status();
      // Control write without byte lane 0 is ignored
      byteEn <= 4'hE;
      bus(1'b1, CONTROL_OFFSET, 32'h0000_0000);
      byteEn <= 4'hF;
      check("byte enable", {31'h0, dmaAssistMode}, 32'h0000_0001);
      bus(1'b0, 32'hfffa_8060, '0);
      check("unmapped", rd, READ_FILL);
      // Sticky command-done event, then mask and clear
      bus(1'b1, IRQ_CLEAR_OFFSET, 32'h0000_001f);
      bus(1'b1, IRQ_ENABLE_OFFSET, 32'h0000_0001);
      irq_chk(1'b0);
      sw_pulse(0);
      card(0);
      irq_chk(1'b1);
      bus(1'b0, IRQ_STATUS_OFFSET, '0);
      check("irq status", rd & 32'h0000_0001, 32'h0000_0001);
      bus(1'b1, IRQ_ENABLE_OFFSET, 32'h0000_0000);
      irq_chk(1'b0);
      bus(1'b1, IRQ_ENABLE_OFFSET, 32'h0000_0001);
      irq_chk(1'b1);
      bus(1'b1, IRQ_CLEAR_OFFSET, 32'h0000_0001);
      irq_chk(1'b0);
      test_done();
   end
endmodule : card_host_status_flags_tb
